// ---- logic/dtmin_map.svh ----
// Register offsets, field positions, reset values and bus codes of the target bank.
`ifndef DTMIN_MAP_SVH
`define DTMIN_MAP_SVH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define DTMIN_IDX_W          6
`define DTMIN_IDX_OP_R1      6'h33
`define DTMIN_IDX_OP_LOC     6'h34
`define DTMIN_IDX_OP_R2      6'h35
`define DTMIN_IDX_CTRL       6'h36
`define DTMIN_IDX_LOCK       6'h3f

// ****************************************************************
// Reset values and field positions.
// ****************************************************************
`define DTMIN_OP_RESET       8'h64
`define DTMIN_CTRL_RESET     8'h00
`define DTMIN_LOCK_RESET     1'b0
`define DTMIN_CTRL_RSVD_MASK 8'hfd
`define DTMIN_BIT_R2_MSB     0
`define DTMIN_BIT_RSVD       1
`define DTMIN_BIT_CAP_BASE   2
`define DTMIN_BIT_DYN_BASE   5
`define DTMIN_BIT_LOCK       0

// ****************************************************************
// Bus answer codes.
// ****************************************************************
`define DTMIN_RESP_OKAY      2'b00
`define DTMIN_RESP_SLVERR    2'b10

`endif

// ---- logic/dtmin_pkg.sv ----
// Types shared by the target register bank and its channel modules.
package dtmin_pkg;

  // ****************************************************************
  // Temperatures are two's complement degrees.
  // ****************************************************************
  typedef logic signed [7:0] dtmin_temp_t;

  typedef struct packed {
    dtmin_temp_t r2;
    dtmin_temp_t loc;
    dtmin_temp_t r1;
  } dtmin_trio_t;

  typedef struct packed {
    logic remote2_dynamic_en;
    logic local_dynamic_en;
    logic remote1_dynamic_en;
    logic remote2_alarm_capture_en;
    logic local_alarm_capture_en;
    logic remote1_alarm_capture_en;
    logic reserved_b1;
    logic remote2_interval_code_msb;
  } dtmin_ctrl_t;

  // ****************************************************************
  // Bus state machines.
  // ****************************************************************
  typedef enum logic [1:0] {
    DTMIN_W_COLLECT = 2'b01,
    DTMIN_W_RESP    = 2'b10
  } dtmin_wst_t;

  typedef enum logic [1:0] {
    DTMIN_R_IDLE = 2'b01,
    DTMIN_R_DATA = 2'b10
  } dtmin_rst_t;

endpackage

// ---- logic/dtmin_op_reg.sv ----
// One operating point register with software write, lock and alarm capture.
`timescale 1ns/100ps
`include "dtmin_map.svh"
module dtmin_op_reg #(
  parameter int             W     = 8,
  parameter logic [W-1:0]   RESET = `DTMIN_OP_RESET
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         wr_en,
  input  wire logic         locked,
  input  wire logic [W-1:0] wdata,
  input  wire logic         capture,
  input  wire logic [W-1:0] cur_temp,
  output logic      [W-1:0] value
);

  if (W < 2) begin : g_chk
    $error("dtmin_op_reg width too small");
  end

  // ****************************************************************
  // Storage.
  // ****************************************************************
  // Capture wins over a write in the same cycle, so an alarm is never lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value <= RESET;
    end else if (capture) begin
      value <= cur_temp;
    end else if (wr_en && !locked) begin
      value <= wdata;
    end
  end

  a_capture_load : assert property (@(posedge aclk) disable iff (!aresetn)
    capture |=> value == $past(cur_temp)) else $error("capture not loaded");

endmodule

// ---- logic/dtmin_min_fan_temperature_adj.sv ----
// Per-channel stepping of the minimum fan temperature to pull the channel temperature toward the target.
`timescale 1ns/100ps
module dtmin_floor_adj (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   enable,
  input  wire logic                   tick,
  input  wire dtmin_pkg::dtmin_temp_t cur_temp,
  input  wire dtmin_pkg::dtmin_temp_t op_point,
  input  wire dtmin_pkg::dtmin_temp_t high_limit,
  input  wire dtmin_pkg::dtmin_temp_t low_limit,
  input  wire dtmin_pkg::dtmin_temp_t min_fan_prog,
  output dtmin_pkg::dtmin_temp_t      min_fan
);

  // ****************************************************************
  // Adjustment.
  // ****************************************************************
  // One degree per interval keeps the fans from hunting around the target.
  // adjust on tick.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      min_fan <= 8'sh00;
    end else if (!enable) begin
      min_fan <= min_fan_prog;
    end else if (tick) begin
      if (cur_temp > op_point && min_fan > low_limit) begin
        min_fan <= min_fan - 8'sh01;
      end else if (cur_temp < op_point && min_fan < high_limit) begin
        min_fan <= min_fan + 8'sh01;
      end
    end
  end

  a_floor_disabled : assert property (@(posedge aclk) disable iff (!aresetn)
    !enable |=> min_fan == $past(min_fan_prog)) else $error("floor moved while off");

  a_floor_lower : assert property (@(posedge aclk) disable iff (!aresetn)
    enable && tick && cur_temp > op_point && min_fan > low_limit
    |=> min_fan == $past(min_fan) - 8'sh01) else $error("floor not lowered");

  a_floor_raise : assert property (@(posedge aclk) disable iff (!aresetn)
    enable && tick && cur_temp < op_point && min_fan < high_limit
    |=> min_fan == $past(min_fan) + 8'sh01) else $error("floor not raised");

endmodule

// ---- logic/dtmin_regs.sv ----
// Operating point and dynamic control register bank on an AXI4-Lite slave.
//
// Contract
// - Three 8-bit read/write target registers, one per channel, each resetting to 0x64.
// - With dynamic control on, each target steers its channel's fan control.
// - Once locked, target registers ignore every later software write.
// - Once locked, the dynamic control register ignores every later write.
// - Dynamic control register resets to zero, all features off.
// - Control bit 0 is the top bit of the remote 2 interval code.
// - Control bit 1 is reserved, reads zero, writes ignored.
// - Capture bit 2 loads remote 1 temperature on alarm assertion.
// - Capture bit 3 loads local temperature on alarm assertion.
// - Capture bit 4 loads remote 2 temperature on alarm assertion.
// - A clear capture bit ignores alarms; target keeps programmed value.
// - Bit 5 enables remote 1 minimum temperature adjustment within limits.
// - Bit 6 enables local minimum temperature adjustment within limits.
// - Bit 7 enables remote 2 minimum temperature adjustment within limits.
// - Clear enable leaves minimum temperature at its programmed value.
// - Temperatures, captured ones included, are two's complement.
`timescale 1ns/100ps
`include "dtmin_map.svh"
module dtmin_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [ADDR_W-1:0]      s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   thermal_alarm_pin_n,
  input  wire dtmin_pkg::dtmin_trio_t cur_temp,
  input  wire dtmin_pkg::dtmin_trio_t high_limit,
  input  wire dtmin_pkg::dtmin_trio_t low_limit,
  input  wire dtmin_pkg::dtmin_trio_t min_fan_prog,
  input  wire logic [2:0]             adj_tick,
  output dtmin_pkg::dtmin_trio_t      op_point,
  output dtmin_pkg::dtmin_trio_t      min_fan_temperature,
  output logic [2:0]                  dynamic_en,
  output logic                        remote2_interval_code_msb,
  output logic                        config_locked
);

  if (ADDR_W < 8) begin : g_chk
    $error("dtmin_regs address width below 8");
  end

  localparam logic [`DTMIN_IDX_W-1:0] OP_IDX [3] = '{
    `DTMIN_IDX_OP_R1, `DTMIN_IDX_OP_LOC, `DTMIN_IDX_OP_R2};

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  dtmin_pkg::dtmin_wst_t      wst_r;
  dtmin_pkg::dtmin_rst_t      rst_r;
  dtmin_pkg::dtmin_ctrl_t     ctrl_r;
  logic                       lock_r;
  logic                       aw_held_r;
  logic                       w_held_r;
  logic [ADDR_W-1:0]          awaddr_r;
  logic [7:0]                 wdata_r;
  logic                       wstrb0_r;
  logic                       do_write;
  logic [`DTMIN_IDX_W-1:0]    wr_idx;
  logic                       wr_hit;
  logic                       wr_known;
  logic [`DTMIN_IDX_W-1:0]    rd_idx;
  logic                       rd_hit;
  logic                       rd_known;
  logic [7:0]                 rd_byte;
  logic                       alarm_prev_r;
  logic                       alarm_fall;
  logic [2:0]                 cap_en;
  logic [2:0][7:0]            cur_arr;
  logic [2:0][7:0]            hi_arr;
  logic [2:0][7:0]            lo_arr;
  logic [2:0][7:0]            prog_arr;
  logic [2:0][7:0]            op_arr;
  logic [2:0][7:0]            min_fan_arr;
  logic [2:0]                 op_wr;

  assign cur_arr  = cur_temp;
  assign hi_arr   = high_limit;
  assign lo_arr   = low_limit;
  assign prog_arr = min_fan_prog;
  assign op_point = op_arr;
  assign min_fan_temperature = min_fan_arr;

  // ****************************************************************
  // Write channel.
  // ****************************************************************
  assign s_axi_awready = (wst_r == dtmin_pkg::DTMIN_W_COLLECT) && !aw_held_r;
  assign s_axi_wready  = (wst_r == dtmin_pkg::DTMIN_W_COLLECT) && !w_held_r;
  assign s_axi_bvalid  = (wst_r == dtmin_pkg::DTMIN_W_RESP);
  assign do_write = (wst_r == dtmin_pkg::DTMIN_W_COLLECT) && aw_held_r && w_held_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  // Only the low byte lane carries register bits, so only its strobe matters.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r  <= 8'h00;
      wstrb0_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r  <= s_axi_wdata[7:0];
      wstrb0_r <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  always_comb begin
    wr_idx   = awaddr_r[7:2];
    wr_hit   = (awaddr_r >> 8) == '0;
    wr_known = wr_hit && (wr_idx == OP_IDX[0] || wr_idx == OP_IDX[1] ||
               wr_idx == OP_IDX[2] || wr_idx == `DTMIN_IDX_CTRL ||
               wr_idx == `DTMIN_IDX_LOCK);
  end

  // A locked write is dropped silently and still answers OKAY.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_r       <= dtmin_pkg::DTMIN_W_COLLECT;
      s_axi_bresp <= `DTMIN_RESP_OKAY;
    end else begin
      unique case (wst_r)
        dtmin_pkg::DTMIN_W_COLLECT: begin
          if (do_write) begin
            wst_r       <= dtmin_pkg::DTMIN_W_RESP;
            s_axi_bresp <= wr_known ? `DTMIN_RESP_OKAY : `DTMIN_RESP_SLVERR;
          end
        end
        dtmin_pkg::DTMIN_W_RESP: begin
          if (s_axi_bready) begin
            wst_r <= dtmin_pkg::DTMIN_W_COLLECT;
          end
        end
        default: begin
          wst_r <= dtmin_pkg::DTMIN_W_COLLECT;
        end
      endcase
    end
  end

  // ****************************************************************
  // Lock and control registers.
  // ****************************************************************
  // The lock only falls at reset, so firmware cannot undo a locked setup.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_r <= `DTMIN_LOCK_RESET;
    end else if (do_write && wstrb0_r && wr_hit && wr_idx == `DTMIN_IDX_LOCK &&
                 wdata_r[`DTMIN_BIT_LOCK]) begin
      lock_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `DTMIN_CTRL_RESET;
    end else if (do_write && wstrb0_r && wr_hit && wr_idx == `DTMIN_IDX_CTRL && !lock_r) begin
      ctrl_r <= wdata_r & `DTMIN_CTRL_RSVD_MASK;
    end
  end

  assign remote2_interval_code_msb = ctrl_r.remote2_interval_code_msb;
  assign dynamic_en = {ctrl_r.remote2_dynamic_en, ctrl_r.local_dynamic_en,
                       ctrl_r.remote1_dynamic_en};
  assign cap_en     = {ctrl_r.remote2_alarm_capture_en, ctrl_r.local_alarm_capture_en,
                       ctrl_r.remote1_alarm_capture_en};
  assign config_locked = lock_r;

  // ****************************************************************
  // Alarm edge.
  // ****************************************************************
  // new assertion only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_prev_r <= 1'b1;
    end else begin
      alarm_prev_r <= thermal_alarm_pin_n;
    end
  end

  assign alarm_fall = alarm_prev_r && !thermal_alarm_pin_n;

  // ****************************************************************
  // Channels.
  // ****************************************************************
  for (genvar i = 0; i < 3; i++) begin : g_chan
    assign op_wr[i] = do_write && wstrb0_r && wr_hit && wr_idx == OP_IDX[i];

    dtmin_op_reg #(
      .W        (8),
      .RESET    (`DTMIN_OP_RESET)
    ) u_op (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .wr_en    (op_wr[i]),
      .locked   (lock_r),
      .wdata    (wdata_r),
      .capture  (alarm_fall && cap_en[i]),
      .cur_temp (cur_arr[i]),
      .value    (op_arr[i])
    );

    dtmin_floor_adj u_adj (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .enable       (dynamic_en[i]),
      .tick         (adj_tick[i]),
      .cur_temp     (cur_arr[i]),
      .op_point     (op_arr[i]),
      .high_limit   (hi_arr[i]),
      .low_limit    (lo_arr[i]),
      .min_fan_prog (prog_arr[i]),
      .min_fan      (min_fan_arr[i])
    );
  end

  // ****************************************************************
  // Read channel.
  // ****************************************************************
  assign s_axi_arready = (rst_r == dtmin_pkg::DTMIN_R_IDLE);
  assign s_axi_rvalid  = (rst_r == dtmin_pkg::DTMIN_R_DATA);

  always_comb begin
    rd_idx   = s_axi_araddr[7:2];
    rd_hit   = (s_axi_araddr >> 8) == '0;
    rd_known = rd_hit;
    rd_byte  = 8'h00;
    if (rd_idx == OP_IDX[0]) begin
      rd_byte = op_arr[0];
    end else if (rd_idx == OP_IDX[1]) begin
      rd_byte = op_arr[1];
    end else if (rd_idx == OP_IDX[2]) begin
      rd_byte = op_arr[2];
    end else if (rd_idx == `DTMIN_IDX_CTRL) begin
      rd_byte = ctrl_r;
    end else if (rd_idx == `DTMIN_IDX_LOCK) begin
      rd_byte = {7'h00, lock_r};
    end else begin
      rd_known = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_r       <= dtmin_pkg::DTMIN_R_IDLE;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `DTMIN_RESP_OKAY;
    end else begin
      unique case (rst_r)
        dtmin_pkg::DTMIN_R_IDLE: begin
          if (s_axi_arvalid) begin
            rst_r       <= dtmin_pkg::DTMIN_R_DATA;
            s_axi_rdata <= rd_known ? {24'h000000, rd_byte} : 32'h0000_0000;
            s_axi_rresp <= rd_known ? `DTMIN_RESP_OKAY : `DTMIN_RESP_SLVERR;
          end
        end
        dtmin_pkg::DTMIN_R_DATA: begin
          if (s_axi_rready) begin
            rst_r <= dtmin_pkg::DTMIN_R_IDLE;
          end
        end
        default: begin
          rst_r <= dtmin_pkg::DTMIN_R_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  a_target_reset : assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> op_point == {3{`DTMIN_OP_RESET}}) else $error("bad target reset");

  a_lock_targets : assert property (@(posedge aclk) disable iff (!aresetn)
    lock_r && !alarm_fall |=> $stable(op_point)) else $error("locked target changed");

  a_lock_control : assert property (@(posedge aclk) disable iff (!aresetn)
    lock_r |=> $stable(ctrl_r)) else $error("locked control changed");

  a_control_reset : assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> ctrl_r == 8'h00 && dynamic_en == 3'b000) else $error("bad ctrl reset");

  a_code_msb : assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && wstrb0_r && wr_idx == `DTMIN_IDX_CTRL && wr_hit && !lock_r
    |=> remote2_interval_code_msb == $past(wdata_r[0])) else $error("code msb not taken");

  a_reserved_zero : assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && $past(s_axi_arvalid && rd_idx == `DTMIN_IDX_CTRL)
    |-> s_axi_rdata[1] == 1'b0) else $error("reserved bit set");

  a_local_capture : assert property (@(posedge aclk) disable iff (!aresetn)
    alarm_fall && ctrl_r.local_alarm_capture_en
    |=> op_point.loc == $past(cur_temp.loc)) else $error("local not captured");

  a_r2_capture : assert property (@(posedge aclk) disable iff (!aresetn)
    alarm_fall && ctrl_r.remote2_alarm_capture_en
    |=> op_point.r2 == $past(cur_temp.r2)) else $error("remote 2 not captured");

  a_no_capture : assert property (@(posedge aclk) disable iff (!aresetn)
    alarm_fall && !ctrl_r.remote1_alarm_capture_en && !op_wr[0]
    |=> $stable(op_point.r1)) else $error("ignored alarm captured");

  a_single_capture : assert property (@(posedge aclk) disable iff (!aresetn)
    !thermal_alarm_pin_n [*2] ##0 (op_wr == 3'b000) |=> $stable(op_point))
    else $error("repeat capture");

  a_write_answer : assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid) else $error("write not answered");

endmodule

// ---- verification/dtmin_regs_bench.sv ----
// Self-checking bench for the target temperature register bank.
`timescale 1ns/100ps
module dtmin_regs_bench;
  // ****************************************************************
  // Stimulus and observed signals.
  // ****************************************************************
  logic                   aclk      = 1'b0;
  logic                   aresetn   = 1'b0;
  logic [7:0]             awaddr    = 8'h00;
  logic [7:0]             araddr    = 8'h00;
  logic [31:0]            wdata     = 32'h0;
  logic                   awvalid   = 1'b0;
  logic                   wvalid    = 1'b0;
  logic                   bready    = 1'b0;
  logic                   arvalid   = 1'b0;
  logic                   rready    = 1'b0;
  logic                   alarm_n   = 1'b1;
  logic [2:0]             adj_tick  = 3'h0;
  dtmin_pkg::dtmin_trio_t cur_temp  = 24'h000000;
  dtmin_pkg::dtmin_trio_t hi_lim    = 24'h505050;
  dtmin_pkg::dtmin_trio_t lo_lim    = 24'h050505;
  dtmin_pkg::dtmin_trio_t min_fan_prog = 24'h000000;
  logic                   awready, wready, bvalid, arready, rvalid, msb, locked;
  logic [1:0]             bresp, rresp;
  logic [31:0]            rdata;
  logic [2:0]             dyn_en;
  dtmin_pkg::dtmin_trio_t op_pt, mft;
  int                     err_total = 0;
  int                     n_tests   = 0;

  always #50 aclk = ~aclk;

  dtmin_regs #(.ADDR_W(8)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .thermal_alarm_pin_n(alarm_n), .cur_temp(cur_temp),
    .high_limit(hi_lim), .low_limit(lo_lim), .min_fan_prog(min_fan_prog),
    .adj_tick(adj_tick), .op_point(op_pt), .min_fan_temperature(mft),
    .dynamic_en(dyn_en), .remote2_interval_code_msb(msb), .config_locked(locked)
  );

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Both channels are offered together and each is released as it is taken.
  // Only the watchdog ends a wait that never sees the answer.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic pulse_alarm();
    alarm_n <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Rows: address, data written, value read back, response.
  // ****************************************************************
  localparam int NR = 7;
  logic [7:0] row_a [NR] = '{8'hcc, 8'hd0, 8'hd4, 8'hd8, 8'hd8, 8'hd8, 8'h40};
  logic [7:0] row_d [NR] = '{8'h5a, 8'h80, 8'h7f, 8'hff, 8'h02, 8'ha5, 8'h11};
  logic [7:0] row_q [NR] = '{8'h5a, 8'h80, 8'h7f, 8'hfd, 8'h00, 8'ha5, 8'h00};
  logic [1:0] row_s [NR] = '{2'b00, 2'b00, 2'b00, 2'b00, 2'b00, 2'b00, 2'b10};

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      rd(8'hcc + 8'(4 * i), d, r);
      chk("reset value", (i == 3) ? 32'h0 : 32'h64, d);
    end
    $display("test reset finished");
    for (int i = 0; i < NR; i++) begin
      wr(row_a[i], {24'h0, row_d[i]}, r);
      chk("write resp", {30'h0, row_s[i]}, {30'h0, r});
      rd(row_a[i], d, r);
      chk("read data", {24'h0, row_q[i]}, d);
      chk("read resp", {30'h0, row_s[i]}, {30'h0, r});
    end
    chk("dynamic enables", 32'h5, {29'h0, dyn_en});
    chk("interval msb", 32'h1, {31'h0, msb});
    $display("test rows finished");
    wr(8'hd8, 32'h14, r);
    cur_temp <= {8'hf6, 8'h33, 8'h9c};
    pulse_alarm();
    chk("capture", 32'hf6809c, {8'h0, op_pt});
    cur_temp <= {8'h01, 8'h02, 8'h03};
    repeat (3) @(posedge aclk);
    chk("held alarm", 32'hf6809c, {8'h0, op_pt});
    alarm_n <= 1'b1;
    wr(8'hd8, 32'h08, r);
    pulse_alarm();
    chk("local capture", 32'hf6029c, {8'h0, op_pt});
    alarm_n <= 1'b1;
    wr(8'hd8, 32'h14, r);
    pulse_alarm();
    alarm_n <= 1'b1;
    chk("second capture", 32'h010203, {8'h0, op_pt});
    $display("test capture finished");
    min_fan_prog <= {8'h10, 8'h20, 8'h30};
    cur_temp <= {8'h01, 8'h02, 8'h20};
    wr(8'hd8, 32'h20, r);
    chk("follow prog", 32'h102030, {8'h0, mft});
    adj_tick <= 3'h7;
    @(posedge aclk);
    adj_tick <= 3'h0;
    cur_temp <= {8'h01, 8'h02, 8'hf0};
    repeat (2) @(posedge aclk);
    chk("step down", 32'h10202f, {8'h0, mft});
    adj_tick <= 3'h1;
    @(posedge aclk);
    adj_tick <= 3'h0;
    repeat (2) @(posedge aclk);
    chk("signed step up", 32'h102030, {8'h0, mft});
    $display("test adjust finished");
    wr(8'hfc, 32'h1, r);
    chk("lock", 32'h1, {31'h0, locked});
    wr(8'hcc, 32'h11, r);
    wr(8'hd8, 32'hff, r);
    rd(8'hcc, d, r);
    chk("locked target", 32'h03, d);
    rd(8'hd8, d, r);
    chk("locked control", 32'h20, d);
    $display("test lock finished");
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("second reset targets", 32'h646464, {8'h0, op_pt});
    chk("second reset lock", 32'h0, {31'h0, locked});
    chk("second reset control", 32'h0, {28'h0, dyn_en, msb});
    $display("test second reset finished");
    print_verdict();
  end

  // A hung handshake ends the run here instead of stalling forever.
  initial begin
    repeat (4000) @(posedge aclk);
    err_total++;
    print_verdict();
  end
endmodule
